// *** src/sbq_query.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sbq_defs.svh"
module sbq_query import sbq_pkg::*; #(
  parameter int          CNT_W  = 20,
  parameter logic [15:0] SUM_LO = `SBQ_SUM_LO,
  parameter logic [15:0] SUM_HI = `SBQ_SUM_HI
) (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic       rx_pin,
  input  wire logic       sec_lock,
  input  wire logic [7:0] flash_rd_data,
  input  wire logic       flash_rd_err,
  output logic            tx_pin,
  output logic            flash_rd_en,
  output logic [15:0]     flash_rd_addr,
  output logic            boot_idle
);
  localparam int W2 = CNT_W + 3;
  // the record payload as a named constant so single bytes can be selected
  localparam logic [8*`SBQ_ID_BYTES-1:0] ID_PL = `SBQ_ID_PAYLOAD;

  logic             rx_s1_r, rx_s2_r, rx_s3_r;
  logic             rx_lvl_r, rx_prev_r;
  sbq_state_t       state_r, state_nxt;
  sbq_state_t       next_r, next_nxt;
  sbq_kind_t        kind_r, kind_nxt;
  logic [4:0]       len_r, len_nxt;
  logic [4:0]       idx_r, idx_nxt;
  logic [7:0]       echo_r, echo_nxt;
  logic [7:0]       err_r, err_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [CNT_W-1:0] lo_r, lo_nxt;
  logic [CNT_W-1:0] hi_r, hi_nxt;
  logic [CNT_W-1:0] bit_r, bit_nxt;
  logic [W2-1:0]    wait_r, wait_nxt;
  logic [15:0]      addr_r, addr_nxt;
  logic             rd_en_r, rd_en_nxt;
  logic             acc_v_r;
  logic [15:0]      sum_r, sum_nxt;
  logic             blank_r, blank_nxt;
  logic             serr_r, serr_nxt;
  logic             idle_r;
  sbq_tx_req_t      tx_req_r, tx_req_nxt;
  sbq_rx_evt_t      rx_evt;
  logic             tx_busy;
  logic [7:0]       id_tab [0:`SBQ_ID_BYTES-1];
  logic [7:0]       id_sum;

  assign flash_rd_en   = rd_en_r;
  assign flash_rd_addr = addr_r;
  assign boot_idle     = idle_r;

  // pin input: three stages, a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_s1_r   <= 1'b1;
      rx_s2_r   <= 1'b1;
      rx_s3_r   <= 1'b1;
      rx_lvl_r  <= 1'b1;
      rx_prev_r <= 1'b1;
    end else begin
      rx_s1_r   <= rx_pin;
      rx_s2_r   <= rx_s1_r;
      rx_s3_r   <= rx_s2_r;
      rx_lvl_r  <= (rx_s2_r == rx_s3_r) ? rx_s3_r : rx_lvl_r;
      rx_prev_r <= rx_lvl_r;
    end
  end

  wire rx_fall = rx_prev_r & ~rx_lvl_r;
  wire rx_rise = ~rx_prev_r & rx_lvl_r;
  wire rx_en   = (state_r == ST_M2) || (state_r == ST_CMD);

  // both legal first bytes begin with a two-bit high run after the low run;
  // the low run is one high run long for one byte, two and a half for the other
  wire [W2-1:0] lo_x = W2'(lo_r);
  wire [W2-1:0] hi_x = W2'(hi_r);
  wire is_m1a = ((lo_x << 2) >= (hi_x << 1) + hi_x) &&
                ((lo_x << 2) <= (hi_x << 2) + hi_x);
  wire is_m1b = (lo_x >= (hi_x << 1)) && (lo_x <= (hi_x << 1) + hi_x);
  wire hi_ok  = hi_r >= `SBQ_MIN_HI;
  // cycles from the end of the high run to mid stop bit
  wire [W2-1:0] wait_m1a = (hi_x << 1) + (hi_x >> 1) + (hi_x >> 2);
  wire [W2-1:0] wait_m1b = hi_x + (hi_x >> 2);

  wire rx_ok    = rx_evt.valid & ~rx_evt.ferr;
  wire m2_good  = (rx_evt.data == `SBQ_MATCH2_A) ||
                  (rx_evt.data == `SBQ_MATCH2_B);
  wire tx_free  = ~tx_req_r.go & ~tx_busy;

  genvar g;
  generate
    for (g = 0; g < `SBQ_ID_BYTES; g++) begin : g_id
      assign id_tab[g] = ID_PL[151-8*g -: 8];
    end
  endgenerate

  always_comb begin
    id_sum = 8'h00;
    for (int i = 0; i < `SBQ_ID_BYTES; i++) begin
      id_sum = id_sum + id_tab[i];
    end
  end

  wire [7:0] id_ck   = 8'h00 - id_sum;
  wire [4:0] id_k    = idx_r - 5'h03;
  wire [7:0] id_byte = (idx_r == 5'h00) ? `SBQ_CMD_ID :
                       (idx_r == 5'h01) ? `SBQ_ID_MARK :
                       (idx_r == 5'h02) ? `SBQ_ID_COUNT :
                       (idx_r >= 5'h16) ? id_ck : id_tab[id_k];
  wire [7:0] sum_byte = (idx_r == 5'h00) ?
                        (blank_r ? `SBQ_BLANK_YES : `SBQ_BLANK_NO) :
                        (idx_r == 5'h01) ? sum_r[15:8] : sum_r[7:0];
  wire [7:0] tx_byte  = (kind_r == K_ECHO) ? echo_r :
                        (kind_r == K_ERR)  ? err_r :
                        (kind_r == K_SUM)  ? sum_byte : id_byte;

  always_comb begin
    state_nxt  = state_r;
    next_nxt   = next_r;
    kind_nxt   = kind_r;
    len_nxt    = len_r;
    idx_nxt    = idx_r;
    echo_nxt   = echo_r;
    err_nxt    = err_r;
    cnt_nxt    = cnt_r;
    lo_nxt     = lo_r;
    hi_nxt     = hi_r;
    bit_nxt    = bit_r;
    wait_nxt   = wait_r;
    addr_nxt   = addr_r;
    rd_en_nxt  = 1'b0;
    sum_nxt    = sum_r;
    blank_nxt  = blank_r;
    serr_nxt   = serr_r;
    tx_req_nxt = '{go: 1'b0, data: tx_req_r.data};
    if (acc_v_r) begin
      sum_nxt   = sum_r + {8'h00, flash_rd_data};
      blank_nxt = blank_r & (flash_rd_data == `SBQ_ERASED);
      serr_nxt  = serr_r | flash_rd_err;
    end
    case (state_r)
      ST_AB_WAIT: begin
        if (rx_fall) begin
          state_nxt = ST_AB_LOW;
          cnt_nxt   = CNT_W'(1);
        end
      end
      ST_AB_LOW: begin
        if (rx_rise) begin
          lo_nxt    = cnt_r;
          cnt_nxt   = CNT_W'(1);
          state_nxt = ST_AB_HIGH;
        end else if (&cnt_r) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      ST_AB_HIGH: begin
        if (rx_fall) begin
          hi_nxt    = cnt_r;
          state_nxt = ST_AB_CHK;
        end else if (&cnt_r) begin
          state_nxt = ST_IDLE;
        end else begin
          cnt_nxt = cnt_r + CNT_W'(1);
        end
      end
      ST_AB_CHK: begin
        if (!hi_ok || !(is_m1a || is_m1b)) begin
          state_nxt = ST_IDLE;
        end else begin
          bit_nxt   = hi_r >> 1;
          wait_nxt  = is_m1a ? wait_m1a : wait_m1b;
          echo_nxt  = is_m1a ? `SBQ_MATCH1_A : `SBQ_MATCH1_B;
          state_nxt = ST_AB_STOP;
        end
      end
      ST_AB_STOP: begin
        if (wait_r != '0) begin
          wait_nxt = wait_r - W2'(1);
        end else if (rx_lvl_r) begin
          kind_nxt  = K_ECHO;
          len_nxt   = 5'h01;
          idx_nxt   = 5'h00;
          next_nxt  = ST_M2;
          state_nxt = ST_SEND;
        end else begin
          state_nxt = ST_IDLE;
        end
      end
      ST_M2: begin
        if (rx_evt.valid) begin
          if (rx_ok && m2_good) begin
            echo_nxt  = rx_evt.data;
            kind_nxt  = K_ECHO;
            len_nxt   = 5'h01;
            idx_nxt   = 5'h00;
            next_nxt  = ST_CMD;
            state_nxt = ST_SEND;
          end else begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_CMD: begin
        if (rx_evt.valid) begin
          idx_nxt  = 5'h00;
          next_nxt = ST_CMD;
          if (rx_evt.ferr) begin
            err_nxt   = `SBQ_ERR_COMM;
            kind_nxt  = K_ERR;
            len_nxt   = `SBQ_ERR_LEN;
            next_nxt  = ST_IDLE;
            state_nxt = ST_SEND;
          end else if (sec_lock) begin
            state_nxt = ST_IDLE;
          end else if (rx_evt.data == `SBQ_CMD_SUM) begin
            addr_nxt  = SUM_LO;  // no echo for this command
            sum_nxt   = 16'h0000;
            blank_nxt = 1'b1;
            serr_nxt  = 1'b0;
            state_nxt = ST_SUM;
          end else if (rx_evt.data == `SBQ_CMD_ID) begin
            kind_nxt  = K_ID;
            len_nxt   = `SBQ_ID_LEN;
            state_nxt = ST_SEND;
          end else begin
            err_nxt   = `SBQ_ERR_CMD;
            kind_nxt  = K_ERR;
            len_nxt   = `SBQ_ERR_LEN;
            next_nxt  = ST_IDLE;
            state_nxt = ST_SEND;
          end
        end
      end
      ST_SUM: begin
        rd_en_nxt = 1'b1;
        if (rd_en_r && addr_r == SUM_HI) begin
          rd_en_nxt = 1'b0;
          state_nxt = ST_SUM_END;
        end else if (rd_en_r) begin
          addr_nxt = addr_r + 16'h0001;
        end
      end
      ST_SUM_END: begin
        if (!acc_v_r) begin
          kind_nxt  = K_SUM;
          // a read fault leaves only the blank indicator
          len_nxt   = serr_r ? 5'h01 : `SBQ_SUM_LEN;
          state_nxt = ST_SEND;
        end
      end
      ST_SEND: begin
        if (idx_r < len_r) begin
          if (tx_free) begin
            tx_req_nxt = '{go: 1'b1, data: tx_byte};
            idx_nxt    = idx_r + 5'h01;
          end
        end else if (tx_free) begin
          state_nxt = next_r;
        end
      end
      default: state_nxt = ST_IDLE;  // only reset leaves here
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r  <= ST_AB_WAIT;
      next_r   <= ST_AB_WAIT;
      kind_r   <= K_ECHO;
      len_r    <= 5'h00;
      idx_r    <= 5'h00;
      echo_r   <= 8'h00;
      err_r    <= 8'h00;
      cnt_r    <= '0;
      lo_r     <= '0;
      hi_r     <= '0;
      bit_r    <= '1;
      wait_r   <= '0;
    end else begin
      state_r  <= state_nxt;
      next_r   <= next_nxt;
      kind_r   <= kind_nxt;
      len_r    <= len_nxt;
      idx_r    <= idx_nxt;
      echo_r   <= echo_nxt;
      err_r    <= err_nxt;
      cnt_r    <= cnt_nxt;
      lo_r     <= lo_nxt;
      hi_r     <= hi_nxt;
      bit_r    <= bit_nxt;
      wait_r   <= wait_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_r   <= 16'h0000;
      rd_en_r  <= 1'b0;
      acc_v_r  <= 1'b0;
      sum_r    <= 16'h0000;
      blank_r  <= 1'b1;
      serr_r   <= 1'b0;
      idle_r   <= 1'b0;
      tx_req_r <= '0;
    end else begin
      addr_r   <= addr_nxt;
      rd_en_r  <= rd_en_nxt;
      acc_v_r  <= rd_en_r;  // read data arrives one cycle after the strobe
      sum_r    <= sum_nxt;
      blank_r  <= blank_nxt;
      serr_r   <= serr_nxt;
      idle_r   <= state_nxt == ST_IDLE;
      tx_req_r <= tx_req_nxt;
    end
  end

  sbq_uart #(.CNT_W(CNT_W)) u_uart (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .bit_cyc (bit_r),
    .rx_en   (rx_en),
    .rx_lvl  (rx_lvl_r),
    .rx_evt  (rx_evt),
    .tx_req  (tx_req_r),
    .tx_busy (tx_busy),
    .tx_line (tx_pin)
  );

  wire go_id  = tx_req_r.go && kind_r == K_ID;
  wire go_sum = tx_req_r.go && kind_r == K_SUM;

  property p_m1_echo;
    @(posedge sys_clk) disable iff (!arst_n)
    state_r == ST_AB_CHK && hi_ok && is_m1a |=>
      state_r == ST_AB_STOP && echo_r == `SBQ_MATCH1_A;
  endproperty
  a_m1_echo: assert property (p_m1_echo) else $error("bad first echo");

  property p_m2_reject;
    @(posedge sys_clk) disable iff (!arst_n)
    state_r == ST_M2 && rx_evt.valid && !m2_good |=> state_r == ST_IDLE;
  endproperty
  a_m2_reject: assert property (p_m2_reject) else $error("m2 kept");

  property p_baud_hold;
    @(posedge sys_clk) disable iff (!arst_n)
    state_r inside {ST_M2, ST_CMD, ST_SEND, ST_SUM} |=> $stable(bit_r);
  endproperty
  a_baud_hold: assert property (p_baud_hold) else $error("baud moved");

  property p_err_byte;
    @(posedge sys_clk) disable iff (!arst_n)
    tx_req_r.go && kind_r == K_ERR |->
      tx_req_r.data == err_r && next_r == ST_IDLE && len_r == 5'h03;
  endproperty
  a_err_byte: assert property (p_err_byte) else $error("bad error");

  property p_sum_start;
    @(posedge sys_clk) disable iff (!arst_n)
    state_r == ST_CMD && rx_ok && !sec_lock &&
      rx_evt.data == `SBQ_CMD_SUM |=>
      state_r == ST_SUM && !tx_req_r.go ##1 rd_en_r && addr_r == SUM_LO;
  endproperty
  a_sum_start: assert property (p_sum_start) else $error("no sum");

  property p_blank;
    @(posedge sys_clk) disable iff (!arst_n)
    go_sum && idx_r == 5'h01 |->
      tx_req_r.data == (blank_r ? `SBQ_BLANK_YES : `SBQ_BLANK_NO);
  endproperty
  a_blank: assert property (p_blank) else $error("bad blank byte");

  property p_sum_hi;
    @(posedge sys_clk) disable iff (!arst_n)
    go_sum && idx_r == 5'h02 |-> !serr_r && tx_req_r.data == sum_r[15:8];
  endproperty
  a_sum_hi: assert property (p_sum_hi) else $error("bad sum high");

  property p_return;
    @(posedge sys_clk) disable iff (!arst_n)
    state_r == ST_SEND && kind_r inside {K_SUM, K_ID} &&
      idx_r == len_r && tx_free |=> state_r == ST_CMD;
  endproperty
  a_return: assert property (p_return) else $error("no command wait");

  property p_id_head;
    @(posedge sys_clk) disable iff (!arst_n)
    go_id && idx_r < 5'h04 |-> tx_req_r.data ==
      (idx_r == 5'h01 ? `SBQ_CMD_ID :
       idx_r == 5'h02 ? `SBQ_ID_MARK : `SBQ_ID_COUNT);
  endproperty
  a_id_head: assert property (p_id_head) else $error("bad id head");

  property p_id_body;
    @(posedge sys_clk) disable iff (!arst_n)
    go_id && idx_r >= 5'h04 && idx_r <= 5'h16 |->
      tx_req_r.data == id_tab[idx_r - 5'h04];
  endproperty
  a_id_body: assert property (p_id_body) else $error("bad id body");

  property p_id_ck;
    @(posedge sys_clk) disable iff (!arst_n)
    go_id && idx_r == 5'h17 |-> 8'(id_sum + tx_req_r.data) == 8'h00;
  endproperty
  a_id_ck: assert property (p_id_ck) else $error("bad id checksum");

  property p_idle_stays;
    @(posedge sys_clk) disable iff (!arst_n)
    state_r == ST_IDLE |=> state_r == ST_IDLE && !tx_req_r.go && idle_r;
  endproperty
  a_idle_stays: assert property (p_idle_stays) else $error("left idle");

  property p_comm_err;
    @(posedge sys_clk) disable iff (!arst_n)
    state_r == ST_CMD && rx_evt.valid && rx_evt.ferr |=>
      kind_r == K_ERR && next_r == ST_IDLE;
  endproperty
  a_comm_err: assert property (p_comm_err) else $error("error not idle");

  property p_accum;
    @(posedge sys_clk) disable iff (!arst_n)
    acc_v_r |=> sum_r == 16'($past(sum_r) + {8'h00, $past(flash_rd_data)});
  endproperty
  a_accum: assert property (p_accum) else $error("bad accumulate");
endmodule
`default_nettype wire

// *** src/sbq_defs.svh ***
// Contract
// - first matching byte 0x86 or 0x30 sets the baud; echoed, silent on failure
// - second matching byte 0x79 or 0xCF echoed when accepted, silent otherwise
// - every byte after the first uses the baud found on the first byte
// - rejected command byte: three identical error bytes, then idle
// - checksum command 0x90 starts the response with no echo byte
// - first checksum response byte is 0xAA if all covered bytes are 0xFF, else 0x55
// - checksum follows as high byte then low byte; neither is sent on error
// - after a query response the device waits for the next command byte
// - identification command 0xC0 is echoed before the record
// - record starts with mark 0x3A then byte count 0x13
// - payload opens with address length 0x03, reserved 0xFD, three 0x00
// - size code 0xF0, block count 0x01, flash range 0x001000 to 0x00FFFF
// - loader RAM range 0x000060 to 0x000C3F, most significant byte first
// - record ends with two's complement of the payload byte sum
// - security enabled or password failure: stop talking, stay idle
// - communication error while receiving protected data: stop talking, go idle; code sends three 0xA3 bytes first, even with sec_lock set
`ifndef SBQ_DEFS_SVH
`define SBQ_DEFS_SVH

`define SBQ_MATCH1_A  8'h86
`define SBQ_MATCH1_B  8'h30
`define SBQ_MATCH2_A  8'h79
`define SBQ_MATCH2_B  8'hCF
`define SBQ_CMD_SUM   8'h90
`define SBQ_CMD_ID    8'hC0
`define SBQ_ERR_CMD   8'hA1
`define SBQ_ERR_COMM  8'hA3
`define SBQ_ERR_OTHER 8'h63
`define SBQ_BLANK_YES 8'hAA
`define SBQ_BLANK_NO  8'h55
`define SBQ_ERASED    8'hFF
`define SBQ_ID_MARK   8'h3A
`define SBQ_ID_COUNT  8'h13
`define SBQ_ID_BYTES  19
`define SBQ_ID_PAYLOAD 152'h03FD000000F00100100000FFFF000060000C3F
`define SBQ_ID_LEN    5'h17
`define SBQ_ERR_LEN   5'h03
`define SBQ_SUM_LEN   5'h03
`define SBQ_SUM_LO    16'h1000
`define SBQ_SUM_HI    16'hFFFF
`define SBQ_MIN_HI    20'h00008

`endif

// *** src/sbq_pkg.sv ***
package sbq_pkg;

  typedef enum logic [3:0] {
    ST_AB_WAIT, ST_AB_LOW, ST_AB_HIGH, ST_AB_CHK, ST_AB_STOP,
    ST_M2, ST_CMD, ST_SUM, ST_SUM_END, ST_SEND, ST_IDLE
  } sbq_state_t;

  typedef enum logic [1:0] {K_ECHO, K_ERR, K_SUM, K_ID} sbq_kind_t;

  typedef struct packed {
    logic       go;
    logic [7:0] data;
  } sbq_tx_req_t;

  typedef struct packed {
    logic       valid;
    logic       ferr;
    logic [7:0] data;
  } sbq_rx_evt_t;

endpackage

// *** src/sbq_uart.sv ***
`timescale 1ns/100ps
`default_nettype none
module sbq_uart import sbq_pkg::*; #(
  parameter int CNT_W = 20
) (
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  input  wire logic [CNT_W-1:0] bit_cyc,
  input  wire logic             rx_en,
  input  wire logic             rx_lvl,
  output sbq_rx_evt_t           rx_evt,
  input  wire sbq_tx_req_t      tx_req,
  output logic                  tx_busy,
  output logic                  tx_line
);
  logic             rx_prev_r;
  logic             rx_act_r;
  logic [CNT_W-1:0] rx_cnt_r;
  logic [3:0]       rx_bit_r;
  logic [7:0]       rx_sh_r;
  sbq_rx_evt_t      rx_evt_r;
  logic             tx_act_r;
  logic [CNT_W-1:0] tx_cnt_r;
  logic [3:0]       tx_n_r;
  logic [9:0]       tx_sh_r;
  logic             tx_line_r;

  assign rx_evt  = rx_evt_r;
  assign tx_busy = tx_act_r;
  assign tx_line = tx_line_r;

  // sample in mid bit: half a bit after the start edge, then whole bits
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_prev_r <= 1'b1;
      rx_act_r  <= 1'b0;
      rx_cnt_r  <= '0;
      rx_bit_r  <= 4'h0;
      rx_sh_r   <= 8'h00;
      rx_evt_r  <= '0;
    end else begin
      rx_prev_r      <= rx_lvl;
      rx_evt_r.valid <= 1'b0;
      if (!rx_en) begin
        rx_act_r <= 1'b0;
      end else if (!rx_act_r) begin
        if (rx_prev_r && !rx_lvl) begin
          rx_act_r <= 1'b1;
          rx_cnt_r <= bit_cyc >> 1;
          rx_bit_r <= 4'h0;
        end
      end else if (rx_cnt_r != '0) begin
        rx_cnt_r <= rx_cnt_r - CNT_W'(1);
      end else begin
        rx_cnt_r <= bit_cyc - CNT_W'(1);
        rx_bit_r <= rx_bit_r + 4'h1;
        if (rx_bit_r == 4'h0) begin
          rx_act_r <= ~rx_lvl;  // glitch, not a start bit
        end else if (rx_bit_r < 4'h9) begin
          rx_sh_r <= {rx_lvl, rx_sh_r[7:1]};
        end else begin
          rx_act_r      <= 1'b0;
          rx_evt_r.valid <= 1'b1;
          rx_evt_r.ferr  <= ~rx_lvl;
          rx_evt_r.data  <= rx_sh_r;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_act_r  <= 1'b0;
      tx_cnt_r  <= '0;
      tx_n_r    <= 4'h0;
      tx_sh_r   <= 10'h3FF;
      tx_line_r <= 1'b1;
    end else if (!tx_act_r) begin
      if (tx_req.go) begin
        tx_act_r  <= 1'b1;
        tx_sh_r   <= {1'b1, tx_req.data, 1'b0};
        tx_cnt_r  <= bit_cyc - CNT_W'(1);
        tx_n_r    <= 4'h0;
        tx_line_r <= 1'b0;
      end
    end else if (tx_cnt_r != '0) begin
      tx_cnt_r <= tx_cnt_r - CNT_W'(1);
    end else if (tx_n_r == 4'h9) begin
      tx_act_r <= 1'b0;
    end else begin
      tx_sh_r   <= tx_sh_r >> 1;
      tx_line_r <= tx_sh_r[1];
      tx_n_r    <= tx_n_r + 4'h1;
      tx_cnt_r  <= bit_cyc - CNT_W'(1);
    end
  end
endmodule
`default_nettype wire

// *** tb/sbq_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// programming controller on the far side of the serial link
module sbq_ctrl_model (
  input  wire logic sys_clk,
  input  wire logic rx_line,
  output logic      tx_line
);
  int bit_c = 16;
  int gap   = 0;
  initial tx_line = 1'b1;
  // one baud for every byte; the stop bit is cut short so the echo
  // start bit is never missed
  task automatic send(input logic [7:0] d, input logic stp);
    logic [9:0] f;
    f = {stp, d, 1'b0};
    repeat (gap) begin
      @(posedge sys_clk);
      #1;
    end
    for (int i = 0; i < 10; i++) begin
      tx_line = f[i];
      repeat (i < 9 ? bit_c : bit_c / 2 + 4) @(posedge sys_clk);
      #1;
    end
    tx_line = 1'b1;
  endtask
  // d[8] holds the stop bit; waits out the stop bit before returning
  task automatic recv(input int lim, output bit seen, output logic [8:0] d);
    int n;
    d = 9'h000;
    seen = 1'b0;
    for (n = 0; n < lim && rx_line !== 1'b0; n++) @(posedge sys_clk);
    if (rx_line !== 1'b0) begin
      #1;
      return;
    end
    seen = 1'b1;
    repeat (bit_c / 2) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      repeat (bit_c) @(posedge sys_clk);
      d[i] = rx_line;
    end
    repeat (bit_c / 2 + 1) @(posedge sys_clk);
    #1;
  endtask
endmodule
`default_nettype wire

// *** tb/serial_boot_query_commands_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_boot_query_commands_tb_top;
  // short scan range keeps each checksum run to a few cycles
  localparam logic [15:0] LO = 16'h1000;
  localparam logic [15:0] HI = 16'h100F;
  logic        sys_clk       = 1'b0;
  logic        arst_n        = 1'b0;
  logic        sec_lock      = 1'b0;
  logic        flash_rd_err  = 1'b0;
  logic        blank         = 1'b1;
  logic [7:0]  flash_rd_data = 8'h00;
  logic [15:0] bad_a         = 16'h0000;
  logic [15:0] flash_rd_addr;
  logic [15:0] fa;
  logic        rx_pin;
  logic        tx_pin;
  logic        flash_rd_en;
  logic        boot_idle;
  logic        fe;
  int          failures      = 0;
  int          comparisons   = 0;

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  sbq_query #(.CNT_W(20), .SUM_LO(LO), .SUM_HI(HI)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .rx_pin(rx_pin),
    .sec_lock(sec_lock), .flash_rd_data(flash_rd_data),
    .flash_rd_err(flash_rd_err), .tx_pin(tx_pin),
    .flash_rd_en(flash_rd_en), .flash_rd_addr(flash_rd_addr),
    .boot_idle(boot_idle));
  sbq_ctrl_model ctrl (.sys_clk(sys_clk), .rx_line(tx_pin),
    .tx_line(rx_pin));

  function automatic logic [7:0] fbyte(input logic [15:0] a);
    return blank ? 8'hFF : a[7:0] ^ 8'h3C;
  endfunction
  function automatic logic [15:0] exp_sum();
    logic [15:0] s = 16'h0000;
    for (int a = LO; a <= HI; a++) s += 16'(fbyte(16'(a)));
    return s;
  endfunction

  // flash answers the cycle after a strobe; between strobes data is junk
  always @(posedge sys_clk) begin
    fa = flash_rd_addr;
    fe = flash_rd_en;
    #1;
    flash_rd_data = fe ? fbyte(fa) : ~flash_rd_data;
    flash_rd_err = fe && fa == bad_a;
  end

  task automatic wrap_up();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [8:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_flag(input string what, input logic exp, got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic expect_bytes(input string what, input logic [7:0] e[$]);
    bit         seen;
    logic [8:0] d;
    foreach (e[i]) begin
      ctrl.recv(4000, seen, d);
      if (!seen) begin
        failures++;
        $display("MISMATCH %s expected %h seen none", what, e[i]);
        wrap_up();
      end else begin
        chk(what, {1'b1, e[i]}, d);
      end
    end
  endtask
  task automatic expect_quiet(input string what);
    bit         seen;
    logic [8:0] d;
    ctrl.recv(600, seen, d);
    chk_flag(what, 1'b0, seen);
  endtask
  task automatic do_reset();
    arst_n = 1'b0;
    ctrl.bit_c = 16;
    ctrl.gap = 0;
    sec_lock = 1'b0;
    blank = 1'b1;
    bad_a = 16'h0000;
    repeat (6) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    chk_flag("idle left by reset", 1'b0, boot_idle);
  endtask
  task automatic hello(input logic [7:0] m1, m2);
    ctrl.send(m1, 1'b1);
    expect_bytes("match1 echo", {m1});
    ctrl.send(m2, 1'b1);
    expect_bytes("match2 echo", {m2});
  endtask

  task automatic sc_id_then_sum();
    logic [7:0]  q[$];
    logic [7:0]  s;
    logic [15:0] t;
    do_reset();
    hello(8'h86, 8'h79);
    q = {8'h03, 8'hFD, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h01, 8'h00, 8'h10,
         8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h60, 8'h00, 8'h0C,
         8'h3F};
    s = 8'h00;
    foreach (q[i]) s += q[i];
    s = ~s + 8'h01;
    q = {8'hC0, 8'h3A, 8'h13, q, s};
    ctrl.send(8'hC0, 1'b1);
    expect_bytes("id record", q);
    ctrl.gap = 300;
    ctrl.send(8'h90, 1'b1);
    t = exp_sum();
    expect_bytes("blank sum", {8'hAA, t[15:8], t[7:0]});
    chk_flag("awake after queries", 1'b0, boot_idle);
  endtask
  task automatic sc_sum_data();
    logic [15:0] t;
    do_reset();
    blank = 1'b0;
    ctrl.bit_c = 20;
    hello(8'h30, 8'hCF);
    ctrl.send(8'h90, 1'b1);
    t = exp_sum();
    expect_bytes("data sum", {8'h55, t[15:8], t[7:0]});
  endtask
  task automatic sc_sum_fault();
    do_reset();
    blank = 1'b0;
    bad_a = LO + 16'h0005;
    hello(8'h86, 8'hCF);
    ctrl.send(8'h90, 1'b1);
    expect_bytes("sum with fault", {8'h55});
    expect_quiet("no sum after fault");
    ctrl.send(8'hC0, 1'b1);
    expect_bytes("next command", {8'hC0, 8'h3A});
  endtask
  task automatic sc_cmd_errors();
    do_reset();
    hello(8'h86, 8'h79);
    ctrl.send(8'h12, 1'b1);
    expect_bytes("unknown command", {8'hA1, 8'hA1, 8'hA1});
    expect_quiet("after error bytes");
    chk_flag("idle after unknown", 1'b1, boot_idle);
    ctrl.send(8'h90, 1'b1);
    expect_quiet("idle ignores commands");
    do_reset();
    hello(8'h30, 8'h79);
    ctrl.send(8'hC0, 1'b0);
    expect_bytes("framing fault", {8'hA3, 8'hA3, 8'hA3});
    chk_flag("idle after framing", 1'b1, boot_idle);
  endtask
  task automatic sc_refusals();
    do_reset();
    ctrl.send(8'h0E, 1'b1);
    expect_quiet("bad first match");
    chk_flag("idle after first", 1'b1, boot_idle);
    do_reset();
    ctrl.send(8'h86, 1'b1);
    expect_bytes("match1 echo", {8'h86});
    ctrl.send(8'h12, 1'b1);
    expect_quiet("bad second match");
    chk_flag("idle after second", 1'b1, boot_idle);
    do_reset();
    sec_lock = 1'b1;
    hello(8'h86, 8'h79);
    ctrl.send(8'hC0, 1'b1);
    expect_quiet("locked");
    chk_flag("idle when locked", 1'b1, boot_idle);
  endtask

  initial begin
    sc_id_then_sum();
    sc_sum_data();
    sc_sum_fault();
    sc_cmd_errors();
    sc_refusals();
    wrap_up();
  end
endmodule
`default_nettype wire
